// file: dv/ctsc_electrodes.sv
// Electrode and trigger model for the far side of the touch scanner
`timescale 1ns/10ps
module ctsc_electrodes (
   input wire logic clk,
   input wire logic [1:0] mode,
   input wire logic [15:0] drv,
   input wire logic [15:0] oe,
   output logic [15:0] pin,
   output logic trig
);
   logic flip = 1'b0;
   logic [8:0] age = 9'h0;
   // Released lines toggle each cycle so a stale level is never mistaken for a drive
   assign pin = (oe & drv) | (~oe & {16{flip}});
   // Mode 0 never triggers, 1 triggers at once, 2 only after about 300 cycles
   assign trig = mode == 2'h1 || (mode == 2'h2 && age > 9'h12c);
   // Slow charge timer restarts on each discharge, saturating so the trigger stays up
   always_ff @(posedge clk) begin
      flip <= !flip;
      age <= (mode != 2'h2 || oe != 16'h0000) ? 9'h0 : age + {8'h0, age != 9'h1ff};
   end
endmodule : ctsc_electrodes

// file: dv/ctsc_scan_asserts.sv
// Checker of bus handshake, status fields and idle pin drive of the touch scanner
`timescale 1ns/10ps
module ctsc_scan_asserts #(
   parameter int PINS = 16
) (
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   input wire logic [11:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic AVS_WAITREQUEST,
   input wire logic [PINS-1:0] SENSE_IN,
   input wire logic [PINS-1:0] SENSE_OUT,
   input wire logic [PINS-1:0] SENSE_OE,
   input wire logic TRIGGER
);
   logic [31:0] ctl;
   logic [5:0] age;
   // Shadow of the last accepted control write; the bench enables all lanes
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST)
         ctl <= 32'h0;
      else if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == ctsc_pkg::OFF_CONTROL)
         ctl <= AVS_WRITEDATA;
   end
   // Cycles since a control write; 63 covers two ticks at the slowest divide
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST)
         age <= 6'h3f;
      else if (AVS_WRITE && AVS_ADDRESS == ctsc_pkg::OFF_CONTROL)
         age <= 6'h0;
      else if (age != 6'h3f)
         age <= age + 6'h1;
   end
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST);
   sequence s_req;
      (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
   endsequence
   sequence s_done(logic [11:0] a);
      AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == a;
   endsequence
   sequence s_calm;
      age == 6'h3f && ctl[1:0] == ctsc_pkg::METHOD_OFF;
   endsequence
   wait_one_a:
      assert property (s_req |=> !AVS_WAITREQUEST) else $error("wait longer than one cycle");
   no_wait_a:
      assert property (!(AVS_READ || AVS_WRITE) |-> !AVS_WAITREQUEST) else $error("idle wait");
   read_hold_a:
      assert property (!AVS_READ |=> $stable(AVS_READDATA)) else $error("read data moved");
   unmapped_zero_a:
      assert property (s_done(12'h00c) |-> AVS_READDATA == 32'h0) else $error("unmapped not 0");
   pin_count_a:
      assert property (s_done(ctsc_pkg::OFF_STATUS) |-> AVS_READDATA[19:16] == 4'(PINS-1))
      else $error("pin count field wrong");
   pend_clear_a:
      assert property (s_done(ctsc_pkg::OFF_CONTROL) ##0 age == 6'h3f |-> !AVS_READDATA[15])
      else $error("pending stuck high");
   busy_idle_a:
      assert property (s_done(ctsc_pkg::OFF_STATUS) ##0 s_calm |-> !AVS_READDATA[8])
      else $error("busy while inactive");
   idle_drive_a:
      assert property (s_calm |-> SENSE_OE ==
         (ctl[13:12] == ctsc_pkg::IDLE_LOW ? ctl[16 +: PINS] : '0)) else $error("idle drive");
   drive_low_a:
      assert property ((SENSE_OUT & SENSE_OE) == '0) else $error("pin driven high");
endmodule : ctsc_scan_asserts
bind ctsc_scan ctsc_scan_asserts #(.PINS(PINS)) u_chk (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
   .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
   .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
   .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .SENSE_IN(SENSE_IN),
   .SENSE_OUT(SENSE_OUT), .SENSE_OE(SENSE_OE), .TRIGGER(TRIGGER));

// file: dv/testbench.sv
// Bench of the touch scanner: bus tasks, electrode model and scan scenarios
`timescale 1ns/10ps
module testbench;
   localparam logic [11:0] A_C = ctsc_pkg::OFF_CONTROL;
   localparam logic [11:0] A_S = ctsc_pkg::OFF_STATUS;
   localparam logic [11:0] A_T = ctsc_pkg::OFF_THRESH;
   localparam logic [11:0] A_D = ctsc_pkg::OFF_TOUCH_DATA;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [11:0] addr = 12'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wd = 32'h0;
   logic [31:0] rdata;
   logic wreq;
   logic [15:0] s_in;
   logic [15:0] s_out;
   logic [15:0] s_oe;
   logic trig;
   logic [1:0] pmode = 2'h0;
   logic [31:0] q;
   realtime t0;
   int err_count = 0;
   int checks_done = 0;
   // 40 MHz core clock
   always #12.5 clk = !clk;
   ctsc_scan dut (.CORE_CLK(clk), .SYS_RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd),
      .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata),
      .AVS_WAITREQUEST(wreq), .SENSE_IN(s_in), .SENSE_OUT(s_out), .SENSE_OE(s_oe),
      .TRIGGER(trig));
   ctsc_electrodes model (.clk(clk), .mode(pmode), .drv(s_out), .oe(s_oe), .pin(s_in),
      .trig(trig));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task conclude;
      if (err_count == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : conclude
   // One bus transfer, held until waitrequest is seen low at an edge
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      addr <= a;
      wr <= w;
      rd <= !w;
      wd <= d;
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 20);
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
      if (n == 20)
         chk(32'h1, 32'h0);
   endtask : bus
   task pend;
      int n;
      n = 0;
      do begin
         bus(1'b0, A_C, 32'h0);
         n++;
      end while (q[15] !== 1'b0 && n < 40);
      chk({31'h0, q[15]}, 32'h0);
   endtask : pend
   task wctl(input logic [31:0] d);
      bus(1'b1, A_C, d);
      pend;
   endtask : wctl
   task wbit(input int b);
      int n;
      n = 0;
      do begin
         bus(1'b0, A_S, 32'h0);
         n++;
      end while (q[b] !== 1'b1 && n < 2000);
      chk({31'h0, q[b]}, 32'h1);
   endtask : wbit
   task clr;
      bus(1'b1, A_S, 32'h1f);
   endtask : clr
   function logic [31:0] cv(input logic [15:0] m, input logic [1:0] i, input logic [3:0] dv,
      input logic h, input logic [1:0] md);
      return {m, 2'h0, i, dv, 2'h0, h, 3'h0, md};
   endfunction : cv
   // Threshold fixed at 100 divided cycles; exponents stay at twelve or below
   function logic [31:0] tv(input logic lo, input logic [7:0] iv, input logic [3:0] e);
      return {lo, 7'h0, iv, e, 12'h064};
   endfunction : tv
   task shot(input logic [1:0] m, input logic [31:0] t, input logic [15:0] p,
      input logic [4:0] f);
      pmode <= m;
      bus(1'b1, A_T, t);
      wctl(cv(p, 2'h0, 4'h0, 1'b0, ctsc_pkg::METHOD_SINGLE));
      if (m == 2'h2) begin
         bus(1'b0, A_S, 32'h0);
         chk({31'h0, q[8]}, 32'h1);
      end
      wbit(ctsc_pkg::ST_ROUND);
      chk({27'h0, q[4:0]}, {27'h0, f});
      wctl(cv(p, 2'h0, 4'h0, 1'b0, 2'h0));
      bus(1'b0, A_S, 32'h0);
      chk({31'h0, q[8]}, 32'h0);
   endtask : shot
   task t_regs;
      bus(1'b0, A_C, 32'h0);
      chk(q, ctsc_pkg::RST_CONTROL);
      bus(1'b0, A_S, 32'h0);
      chk(q, 32'h000f_0000);
      bus(1'b1, 12'h00c, 32'hffff_ffff);
      bus(1'b0, 12'h00c, 32'h0);
      chk(q, 32'h0);
      bus(1'b1, A_T, tv(1'b1, 8'h5a, 4'h9));
      bus(1'b0, A_T, 32'h0);
      chk(q, 32'h805a_9064);
   endtask : t_regs
   task t_pins;
      wctl(cv(16'h0005, ctsc_pkg::IDLE_LOW, 4'hf, 1'b0, 2'h0));
      chk(q, 32'h0005_1f00);
      repeat (3) @(posedge clk);
      chk({16'h0, s_oe}, 32'h5);
      // Crossing runs on the live divided clock, so the next change takes two slow ticks
      bus(1'b1, A_C, cv(16'h0005, 2'h0, 4'h0, 1'b0, 2'h0));
      t0 = $realtime;
      bus(1'b0, A_C, 32'h0);
      chk({31'h0, q[15]}, 32'h1);
      pend;
      chk({31'h0, $realtime - t0 > 400.0}, 32'h1);
      bus(1'b1, A_C, cv(16'h0005, 2'h0, 4'h0, 1'b0, 2'h0));
      t0 = $realtime;
      pend;
      chk({31'h0, $realtime - t0 < 400.0}, 32'h1);
      repeat (3) @(posedge clk);
      chk({16'h0, s_oe}, 32'h0);
   endtask : t_pins
   task t_shots;
      shot(2'h1, tv(1'b0, 8'h0, 4'hc), 16'h1, 5'h06);
      bus(1'b1, A_S, 32'h0);
      bus(1'b0, A_S, 32'h0);
      chk({27'h0, q[4:0]}, 32'h6);
      bus(1'b1, A_S, 32'h2);
      bus(1'b0, A_S, 32'h0);
      chk({27'h0, q[4:0]}, 32'h4);
      bus(1'b0, A_D, 32'h0);
      chk({31'h0, q[31] || q[11:0] > 12'h064}, 32'h0);
      clr;
      shot(2'h1, tv(1'b1, 8'h0, 4'hc), 16'h1, 5'h05);
      clr;
      shot(2'h1, tv(1'b1, 8'h0, 4'hc), 16'h1, 5'h15);
      bus(1'b0, A_D, 32'h0);
      clr;
      shot(2'h2, tv(1'b0, 8'h0, 4'hc), 16'h1, 5'h05);
      bus(1'b0, A_D, 32'h0);
      chk({31'h0, q[31] && q[11:0] > 12'h064}, 32'h1);
      clr;
      shot(2'h1, tv(1'b0, 8'h0, 4'hc), 16'h1, 5'h06);
      clr;
      shot(2'h1, tv(1'b0, 8'h0, 4'hc), 16'h1, 5'h06);
      clr;
      shot(2'h0, tv(1'b0, 8'h0, 4'h2), 16'h3, 5'h0c);
      bus(1'b0, A_D, 32'h0);
      chk({16'h0, q[15:0]}, 32'h1004);
      clr;
   endtask : t_shots
   task t_cont;
      pmode <= 2'h1;
      bus(1'b1, A_T, tv(1'b0, 8'h01, 4'hc));
      wctl(cv(16'h1, 2'h0, 4'h0, 1'b0, ctsc_pkg::METHOD_CONT));
      wbit(ctsc_pkg::ST_ROUND);
      bus(1'b1, A_S, 32'h4);
      t0 = $realtime;
      wbit(ctsc_pkg::ST_ROUND);
      chk({31'h0, $realtime - t0 > 102000.0 && $realtime - t0 < 104000.0}, 32'h1);
      bus(1'b1, A_C, cv(16'h1, 2'h0, 4'h0, 1'b0, ctsc_pkg::METHOD_SINGLE));
      pend;
      chk({30'h0, q[1:0]}, 32'h2);
      wctl(cv(16'h1, 2'h0, 4'h0, 1'b0, 2'h0));
      bus(1'b1, A_T, tv(1'b1, 8'h00, 4'hc));
      wctl(cv(16'h1, 2'h0, 4'h0, 1'b1, ctsc_pkg::METHOD_CONT));
      wbit(ctsc_pkg::ST_TOUCHED);
      clr;
      repeat (200) @(posedge clk);
      bus(1'b0, A_S, 32'h0);
      chk({27'h0, q[4:0]}, 32'h0);
      bus(1'b0, A_D, 32'h0);
      wbit(ctsc_pkg::ST_TOUCHED);
      wctl(cv(16'h1, 2'h0, 4'h0, 1'b0, 2'h0));
   endtask : t_cont
   // Main sequence after 20 cycles of reset
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_regs;
      t_pins;
      t_shots;
      t_cont;
      conclude;
   end
   // Watchdog at 60000 cycles, over ten times the expected run
   initial begin
      #1500000;
      err_count++;
      conclude;
   end
endmodule : testbench

// file: verilog/ctsc_divider.sv
// Function clock divider giving a one-cycle tick every divide value plus one cycles
`timescale 1ns/10ps
module ctsc_divider (
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   input wire logic [3:0] DIV_VALUE,
   output logic TICK
);
   logic [3:0] count;

   // Tick when the count reaches the divide value, so 0 ticks every cycle
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         count <= 4'h0;
         TICK <= 1'b0;
      end else if (count >= DIV_VALUE) begin
         count <= 4'h0;
         TICK <= 1'b1;
      end else begin
         count <= count + 4'h1;
         TICK <= 1'b0;
      end
   end
endmodule : ctsc_divider

// file: verilog/ctsc_pkg.sv
// Package of register offsets, field positions and constants for the touch scanner
package ctsc_pkg;
   // Register byte offsets
   localparam logic [11:0] OFF_CONTROL = 12'h000;
   localparam logic [11:0] OFF_STATUS = 12'h004;
   localparam logic [11:0] OFF_THRESH = 12'h008;
   localparam logic [11:0] OFF_TOUCH_DATA = 12'h020;
   // Control fields
   localparam int CTL_METHOD_LSB = 0;
   localparam int CTL_HOLD_BIT = 5;
   localparam int CTL_DIV_LSB = 8;
   localparam int CTL_IDLE_LSB = 12;
   localparam int CTL_PEND_BIT = 15;
   localparam int CTL_MASK_LSB = 16;
   // Status fields
   localparam int ST_TOUCHED = 0;
   localparam int ST_UNTOUCHED = 1;
   localparam int ST_ROUND = 2;
   localparam int ST_TIMEOUT = 3;
   localparam int ST_OVERRUN = 4;
   localparam int ST_BUSY = 8;
   localparam int ST_PINS_LSB = 16;
   // Threshold and timing fields
   localparam int TT_THRESH_LSB = 0;
   localparam int TT_TIMEOUT_EXPONENT_LSB = 12;
   localparam int TT_ROUND_LSB = 16;
   localparam int TT_LOW_BIT = 31;
   // Touch data fields
   localparam int TD_PIN_LSB = 12;
   localparam int TD_TOUCH_BIT = 31;
   // Reset values
   localparam logic [31:0] RST_CONTROL = 32'h0000_0000;
   localparam logic [31:0] RST_THRESH = 32'h0000_0000;
   // Round interval step in divided clock cycles
   localparam logic [19:0] ROUND_STEP = 20'h01000;
   // Polling methods
   localparam logic [1:0] METHOD_OFF = 2'h0;
   localparam logic [1:0] METHOD_SINGLE = 2'h1;
   localparam logic [1:0] METHOD_CONT = 2'h2;
   // Idle pin drive codes
   localparam logic [1:0] IDLE_HIGHZ = 2'h0;
   localparam logic [1:0] IDLE_LOW = 2'h1;
   typedef enum logic [2:0] {CTSC_IDLE, CTSC_SETTLE, CTSC_MEASURE, CTSC_HOLD,
                             CTSC_GAP} ctsc_state_t;
endpackage : ctsc_pkg

// file: verilog/ctsc_scan.sv
// Top of the capacitive touch scanner: Avalon-MM registers, scan sequencer, pin drive
`timescale 1ns/10ps
// Operation
// - Hold after touch until data read
// - Divide clock by divide value plus one
// - Idle enabled pins high-Z or driven low
// - Pending bit high while control change crosses
// - Control high half enables sense pins
// - Status flags cleared by writing one
// - Touched flag set on touch result
// - Untouched flag set on no-touch result
// - Round flag at round or single end
// - Time-out flag when count hits limit
// - Overrun when unread touch data overwritten
// - Unread no-touch data overwritten silently
// - Busy bit high while polling
// - Report pin count minus one
// - Compare trigger count with threshold
// - Time-out at two to exponent
// - Wait 4096 times interval between rounds
// - Low-count bit selects touch direction
// - Method changes only from or to inactive
module ctsc_scan #(
   parameter int PINS = 16
) (
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   input wire logic [11:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic [PINS-1:0] SENSE_IN,
   output logic [PINS-1:0] SENSE_OUT,
   output logic [PINS-1:0] SENSE_OE,
   input wire logic TRIGGER
);
   localparam logic [3:0] PINS_M1 = 4'(PINS - 1);

   logic [31:0] ctl_shadow;
   logic [31:0] ctl_live;
   logic pending;
   logic [1:0] pend_age;
   logic [31:0] timing;
   logic [4:0] flags;
   logic [31:0] touch_data;
   logic data_unread;
   logic tick;
   logic ack;
   logic wr_hit;
   logic rd_data_hit;
   logic [31:0] wmask;
   ctsc_pkg::ctsc_state_t state;
   logic [11:0] meas_count;
   logic [19:0] gap_count;
   logic [3:0] pin_idx;
   logic round_started;
   logic [3:0] div_value;
   logic [1:0] method;
   logic [PINS-1:0] enable_mask;
   logic [1:0] idle_drive;
   logic [11:0] thresh;
   logic [3:0] timeout_exponent_exp;
   logic [12:0] timeout_exponent_limit;
   logic low_is_touch;
   logic is_touch;
   logic timed_out;
   logic done_meas;
   logic last_pin;
   logic [3:0] next_pin;
   logic found_next;
   logic [3:0] first_pin;
   logic found_first;
   logic [31:0] rdata;

   assign div_value = ctl_live[ctsc_pkg::CTL_DIV_LSB +: 4];
   assign method = ctl_live[ctsc_pkg::CTL_METHOD_LSB +: 2];
   assign enable_mask = ctl_live[ctsc_pkg::CTL_MASK_LSB +: PINS];
   assign idle_drive = ctl_live[ctsc_pkg::CTL_IDLE_LSB +: 2];
   assign thresh = timing[ctsc_pkg::TT_THRESH_LSB +: 12];
   assign timeout_exponent_exp = timing[ctsc_pkg::TT_TIMEOUT_EXPONENT_LSB +: 4];
   assign low_is_touch = timing[ctsc_pkg::TT_LOW_BIT];
   // Exponent beyond twelve is left to software to avoid
   assign timeout_exponent_limit = 13'h0001 << timeout_exponent_exp;

   ctsc_divider u_div (
      .CORE_CLK(CORE_CLK),
      .SYS_RST(SYS_RST),
      .DIV_VALUE(div_value),
      .TICK(tick)
   );

   // One wait cycle per access keeps read data registered; writes land at the acknowledge edge
   assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack;
   assign wr_hit = AVS_WRITE & ack;
   assign rd_data_hit = AVS_READ & ack & (AVS_ADDRESS == ctsc_pkg::OFF_TOUCH_DATA);
   assign wmask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                   {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         ack <= 1'b0;
      end else begin
         ack <= (AVS_READ | AVS_WRITE) & ~ack;
      end
   end

   // Control shadow on the bus side; method may only leave or return to inactive
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         ctl_shadow <= ctsc_pkg::RST_CONTROL;
      end else if (wr_hit && AVS_ADDRESS == ctsc_pkg::OFF_CONTROL) begin
         ctl_shadow <= (ctl_shadow & ~wmask) | (AVS_WRITEDATA & wmask);
         if (AVS_BYTEENABLE[0] && ctl_shadow[1:0] != ctsc_pkg::METHOD_OFF &&
             AVS_WRITEDATA[1:0] != ctsc_pkg::METHOD_OFF) begin
            ctl_shadow[1:0] <= ctl_shadow[1:0];
         end
         ctl_shadow[ctsc_pkg::CTL_PEND_BIT] <= 1'b0;
      end else if (state == ctsc_pkg::CTSC_IDLE && ctl_shadow[1:0] == ctsc_pkg::METHOD_SINGLE &&
                   ctl_live[1:0] == ctsc_pkg::METHOD_SINGLE && round_started) begin
         ctl_shadow[1:0] <= ctsc_pkg::METHOD_OFF;
      end
   end

   // Change lands in the live copy on the second divided tick after the write
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         pending <= 1'b0;
         pend_age <= 2'h0;
         ctl_live <= ctsc_pkg::RST_CONTROL;
      end else if (wr_hit && AVS_ADDRESS == ctsc_pkg::OFF_CONTROL) begin
         pending <= 1'b1;
         pend_age <= 2'h0;
      end else if (pending && tick) begin
         if (pend_age == 2'h1) begin
            pending <= 1'b0;
            ctl_live <= ctl_shadow;
         end
         pend_age <= pend_age + 2'h1;
      end else if (!pending) begin
         ctl_live[1:0] <= ctl_shadow[1:0];
      end
   end

   // Timing register; software keeps it steady while polling
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         timing <= ctsc_pkg::RST_THRESH;
      end else if (wr_hit && AVS_ADDRESS == ctsc_pkg::OFF_THRESH) begin
         timing <= (timing & ~wmask) | (AVS_WRITEDATA & wmask);
      end
   end

   // Classification of the finished measurement
   assign timed_out = (state == ctsc_pkg::CTSC_MEASURE) && !TRIGGER &&
                      ({1'b0, meas_count} + 13'h0001 >= timeout_exponent_limit);
   assign done_meas = tick && (state == ctsc_pkg::CTSC_MEASURE) && (TRIGGER || timed_out);
   assign is_touch = low_is_touch ? (meas_count <= thresh) : (meas_count > thresh);

   // Next enabled pin above the current one, and the lowest enabled pin
   always_comb begin
      next_pin = 4'h0;
      found_next = 1'b0;
      first_pin = 4'h0;
      found_first = 1'b0;
      for (int i = PINS - 1; i >= 0; i--) begin
         if (enable_mask[i]) begin
            first_pin = 4'(i);
            found_first = 1'b1;
            if (4'(i) > pin_idx) begin
               next_pin = 4'(i);
               found_next = 1'b1;
            end
         end
      end
   end
   assign last_pin = !found_next;

   // Scan sequencer, stepping on divided ticks
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         state <= ctsc_pkg::CTSC_IDLE;
         meas_count <= 12'h000;
         gap_count <= 20'h00000;
         pin_idx <= 4'h0;
         round_started <= 1'b0;
      end else if (method == ctsc_pkg::METHOD_OFF) begin
         state <= ctsc_pkg::CTSC_IDLE;
         round_started <= 1'b0;
      end else if (tick) begin
         case (state)
            ctsc_pkg::CTSC_IDLE: begin
               if (found_first && !round_started) begin
                  pin_idx <= first_pin;
                  meas_count <= 12'h000;
                  state <= ctsc_pkg::CTSC_SETTLE;
                  round_started <= 1'b1;
               end
            end
            ctsc_pkg::CTSC_SETTLE: begin
               meas_count <= 12'h000;
               state <= ctsc_pkg::CTSC_MEASURE;
            end
            ctsc_pkg::CTSC_MEASURE: begin
               if (TRIGGER || timed_out) begin
                  if (ctl_live[ctsc_pkg::CTL_HOLD_BIT] && is_touch && !timed_out) begin
                     state <= ctsc_pkg::CTSC_HOLD;
                  end else if (!last_pin) begin
                     pin_idx <= next_pin;
                     state <= ctsc_pkg::CTSC_SETTLE;
                  end else if (method == ctsc_pkg::METHOD_CONT) begin
                     gap_count <= 20'(timing[ctsc_pkg::TT_ROUND_LSB +: 8]) * ctsc_pkg::ROUND_STEP;
                     state <= ctsc_pkg::CTSC_GAP;
                  end else begin
                     state <= ctsc_pkg::CTSC_IDLE;
                  end
               end else begin
                  meas_count <= meas_count + 12'h001;
               end
            end
            ctsc_pkg::CTSC_HOLD: begin
               if (!data_unread) begin
                  if (!last_pin) begin
                     pin_idx <= next_pin;
                     state <= ctsc_pkg::CTSC_SETTLE;
                  end else if (method == ctsc_pkg::METHOD_CONT) begin
                     gap_count <= 20'(timing[ctsc_pkg::TT_ROUND_LSB +: 8]) * ctsc_pkg::ROUND_STEP;
                     state <= ctsc_pkg::CTSC_GAP;
                  end else begin
                     state <= ctsc_pkg::CTSC_IDLE;
                  end
               end
            end
            ctsc_pkg::CTSC_GAP: begin
               if (gap_count == 20'h00000) begin
                  state <= ctsc_pkg::CTSC_IDLE;
                  round_started <= 1'b0;
               end else begin
                  gap_count <= gap_count - 20'h00001;
               end
            end
            default: begin
               state <= ctsc_pkg::CTSC_IDLE;
            end
         endcase
      end
   end

   // Touch data capture; a read of the data clears the unread mark
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         touch_data <= 32'h0000_0000;
         data_unread <= 1'b0;
      end else if (done_meas) begin
         touch_data <= 32'h0000_0000;
         // A time-out reports the limit it reached; an exponent of twelve wraps to zero
         touch_data[11:0] <= timed_out ? timeout_exponent_limit[11:0] : meas_count;
         touch_data[ctsc_pkg::TD_PIN_LSB +: 4] <= pin_idx;
         touch_data[ctsc_pkg::TD_TOUCH_BIT] <= is_touch && !timed_out;
         data_unread <= 1'b1;
      end else if (rd_data_hit) begin
         data_unread <= 1'b0;
      end
   end

   // Event flags: a hardware set in the same cycle beats a software clear
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         flags <= 5'h00;
      end else begin
         logic [4:0] set_v;
         logic [4:0] clr_v;
         set_v = 5'h00;
         clr_v = 5'h00;
         if (wr_hit && AVS_ADDRESS == ctsc_pkg::OFF_STATUS && AVS_BYTEENABLE[0]) begin
            clr_v = AVS_WRITEDATA[4:0];
         end
         if (done_meas) begin
            set_v[ctsc_pkg::ST_TOUCHED] = !timed_out && is_touch;
            set_v[ctsc_pkg::ST_UNTOUCHED] = !timed_out && !is_touch;
            set_v[ctsc_pkg::ST_TIMEOUT] = timed_out;
            set_v[ctsc_pkg::ST_OVERRUN] = data_unread && touch_data[ctsc_pkg::TD_TOUCH_BIT];
            set_v[ctsc_pkg::ST_ROUND] = last_pin &&
               !(ctl_live[ctsc_pkg::CTL_HOLD_BIT] && is_touch && !timed_out);
         end
         if (tick && state == ctsc_pkg::CTSC_HOLD && !data_unread && last_pin) begin
            set_v[ctsc_pkg::ST_ROUND] = 1'b1;
         end
         flags <= (flags & ~clr_v) | set_v;
      end
   end

   // Sense pins: measured pin released, other enabled pins per idle drive
   genvar g;
   generate
      for (g = 0; g < PINS; g++) begin : g_pin
         always_ff @(posedge CORE_CLK) begin
            if (SYS_RST) begin
               SENSE_OUT[g] <= 1'b0;
               SENSE_OE[g] <= 1'b0;
            end else begin
               SENSE_OUT[g] <= 1'b0;
               if (enable_mask[g] && state == ctsc_pkg::CTSC_SETTLE && pin_idx == 4'(g)) begin
                  SENSE_OE[g] <= 1'b1; // Discharge before measuring
               end else if (enable_mask[g] && !(state == ctsc_pkg::CTSC_MEASURE &&
                            pin_idx == 4'(g))) begin
                  SENSE_OE[g] <= (idle_drive == ctsc_pkg::IDLE_LOW);
               end else begin
                  SENSE_OE[g] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // Read mux; unmapped addresses read zero
   always_comb begin
      rdata = 32'h0000_0000;
      case (AVS_ADDRESS)
         ctsc_pkg::OFF_CONTROL: begin
            rdata = ctl_shadow;
            rdata[ctsc_pkg::CTL_PEND_BIT] = pending;
            rdata[14] = 1'b0;
         end
         ctsc_pkg::OFF_STATUS: begin
            rdata[4:0] = flags;
            rdata[ctsc_pkg::ST_BUSY] = (state != ctsc_pkg::CTSC_IDLE);
            rdata[ctsc_pkg::ST_PINS_LSB +: 4] = PINS_M1;
         end
         ctsc_pkg::OFF_THRESH: begin
            rdata = timing;
            rdata[30:24] = 7'h00;
         end
         ctsc_pkg::OFF_TOUCH_DATA: begin
            rdata = touch_data;
         end
         default: begin
            rdata = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         AVS_READDATA <= 32'h0000_0000;
      end else if (AVS_READ && !ack) begin
         AVS_READDATA <= rdata;
      end
   end
   // Pad inputs are not used by the sequencer; folded here so they stay read
   logic unused_in;
   assign unused_in = ^SENSE_IN;
endmodule : ctsc_scan
